//--- verif/pwb_power_path_checker.sv
// Port-level assertions for the power path and boost control block.
// Assumes it is bound into pwb_power_path_ctrl and shares its single clock.
`timescale 1ns/1ps
module pwb_chk #(
    parameter int unsigned MS_CYCLES = 10
) (
    // Clock, reset and bus handshake.
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic o_avs_waitrequest,
    // Comparator levels and pins.
    input wire logic i_vbus_uvlo_ok,
    input wire logic i_vbus_above_sleep,
    input wire logic i_vbat_above_lowv,
    input wire logic i_overload,
    input wire logic i_boost_request_pin,
    // Power stage controls.
    input wire logic o_battery_switch_on,
    input wire logic o_bias_regulator_en,
    input wire logic o_boost_run,
    input wire logic [3:0] o_boost_voltage_field,
    input wire logic o_dig_clk_en,
    input wire logic o_int
);
    // ************************************************
    // Helper logic
    // ************************************************
    int unsigned allow_cnt_q;
    // Counts how long boost has been allowed at the raw pins.
    always_ff @(posedge i_clk) begin
        if (i_srst || !(i_boost_request_pin && !i_vbus_above_sleep && i_vbat_above_lowv)) begin
            allow_cnt_q <= 0;
        end else begin
            allow_cnt_q <= allow_cnt_q + 1;
        end
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_srst);
    // ************************************************
    // Assertions
    // ************************************************
    a_wait_one_cycle: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
        else $error("bus access not answered after one wait cycle");
    a_wait_low_pulse: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    a_boost_pin_needed: assert property (!i_boost_request_pin [*8] |-> !o_boost_run)
        else $error("boost runs without request pin");
    a_boost_sleep_needed: assert property (i_vbus_above_sleep [*8] |-> !o_boost_run)
        else $error("boost runs with input above sleep margin");
    a_boost_start_delay: assert property ($rose(o_boost_run) |-> allow_cnt_q >= 28 * MS_CYCLES)
        else $error("boost started before its delay");
    a_overload_opens: assert property (i_overload [*6] |-> !o_battery_switch_on)
        else $error("battery switch closed during overload");
    a_bias_off_battery: assert property (!i_vbus_uvlo_ok [*6] |-> o_bias_regulator_en == o_boost_run)
        else $error("bias regulator on with battery only");
    a_dig_clk_spacing: assert property (o_dig_clk_en |=> !o_dig_clk_en [*8])
        else $error("digital clock enable pulses too close");
    a_int_one_cycle: assert property (o_int |=> !o_int)
        else $error("interrupt pulse longer than one cycle");
    a_boost_voltage_field_held: assert property (!i_avs_write [*3] |-> $stable(o_boost_voltage_field))
        else $error("boost voltage changed without a write");
endmodule

bind pwb_power_path_ctrl pwb_chk #(.MS_CYCLES(MS_CYCLES)) chk_u (.*);

//--- verif/pwb_supply_model.sv
// Adapter model feeding the input rail comparators of the block.
// Assumes the bench decides when the adapter is plugged in.
`timescale 1ns/1ps
module pwb_supply_model (
    // Clock and adapter presence.
    input wire logic i_clk,
    input wire logic i_adapter,
    // Input rail comparator levels.
    output logic o_vbus_uvlo_ok = 1'b0,
    output logic o_vbus_above_sleep = 1'b0,
    output logic o_vbus_src_good = 1'b0
);
    // The rail passes release level before the sleep margin; unplugging drops all at once.
    always_ff @(posedge i_clk) begin
        o_vbus_uvlo_ok <= i_adapter;
        o_vbus_above_sleep <= i_adapter & o_vbus_uvlo_ok;
        o_vbus_src_good <= i_adapter & o_vbus_above_sleep;
    end
endmodule

//--- verif/tb_top.sv
// Self-checking bench of the power path and boost control block.
// Assumes the supply model stands for the adapter and the bench acts as host.
`timescale 1ns/1ps
module tb_top;
    import pwb_pkg::*;
    localparam int MS = 10;
    logic i_clk = 0, i_srst = 1, rd = 0, wr = 0, adapter = 0, pin = 0, qexit = 0;
    logic ovl = 0, bfault = 0, bexit = 1, lowv = 1, bdepl = 1, ovp = 0;
    logic [5:0] addr = 6'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic wreq, bsw, ibs, bias, brun, lbs, tload, dclk, intr, vok, vsleep, vgood;
    logic [3:0] bv;
    logic [1:0] hot;
    logic [7:0] q, v;
    int fail_count = 0, samples_checked = 0, cyc = 0, n;
    // ************************************************
    // Clock, models and device
    // ************************************************
    always #2 i_clk = ~i_clk;
    pwb_supply_model sup_u (.i_clk(i_clk), .i_adapter(adapter), .o_vbus_uvlo_ok(vok),
        .o_vbus_above_sleep(vsleep), .o_vbus_src_good(vgood));
    pwb_power_path_ctrl #(.MS_CYCLES(MS), .WDT_MAX_MS(8)) dut_u (.i_clk(i_clk), .i_srst(i_srst),
        .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
        .i_avs_byteenable(4'hF), .o_avs_readdata(rdata), .o_avs_waitrequest(wreq),
        .i_vbus_uvlo_ok(vok), .i_vbat_uvlo_ok(1'b1), .i_vbat_above_depl(bdepl),
        .i_vbus_above_sleep(vsleep), .i_vbat_above_lowv(lowv), .i_vbat_above_boost_exit(bexit),
        .i_overload(ovl), .i_boost_node_ovp(ovp), .i_boost_fault(bfault), .i_vbus_src_good(vgood),
        .i_boost_request_pin(pin), .i_ship_exit_pin(qexit), .o_battery_switch_on(bsw),
        .o_input_blocking_switch_on(ibs), .o_bias_regulator_en(bias), .o_boost_run(brun),
        .o_boost_voltage_field(bv), .o_hot_threshold_sel(hot), .o_low_battery_sel(lbs),
        .o_test_load_en(tload), .o_dig_clk_en(dclk), .o_int(intr));
    // ************************************************
    // Tasks
    // ************************************************
    // Holds the request until waitrequest is sampled low, then takes the data.
    task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
        @(posedge i_clk);
        addr <= a;
        wdata <= {24'h0, d};
        rd <= !w;
        wr <= w;
        do @(posedge i_clk); while (wreq !== 1'b0);
        q = rdata[7:0];
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    function automatic logic [7:0] dflt(input int i);
        return i == 1 ? 8'h20 : i == 5 ? 8'h30 : i == 6 ? 8'h90 : 8'h00;
    endfunction
    // Cuts a hang short well beyond the expected run length.
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            complete_run();
        end
    end
    // ************************************************
    // Scenarios
    // ************************************************
    initial begin
        void'($urandom(69629));
        repeat (16) @(posedge i_clk);
        i_srst <= 1'b0;
        repeat (4) @(posedge i_clk);
        for (int i = 0; i < 11; i++) begin
            bus(0, 6'(i * 4), 8'h00);
            chk(q, dflt(i));
        end
        chk(bsw, 1);
        chk(bias, 0);
        for (int h = 0; h < 4; h++) begin
            v = (8'($urandom) & 8'hF0) | 8'(h << 2);
            bus(1, 6'h18, v);
            repeat (3) @(negedge i_clk);
            chk(bv, v[7:4]);
            chk(hot, v[3:2]);
        end
        bus(1, 6'h14, 8'h00);
        bus(1, 6'h1C, 8'h20);
        repeat (3) @(negedge i_clk);
        chk(bsw, 0);
        @(posedge i_clk);
        qexit <= 1'b1;
        repeat (6) @(negedge i_clk);
        chk(bsw, 1);
        bus(0, 6'h1C, 8'h00);
        chk(q, 8'h00);
        qexit <= 1'b0;
        bus(1, 6'h1C, 8'h20);
        bus(1, 6'h1C, 8'h00);
        repeat (3) @(negedge i_clk);
        chk(bsw, 1);
        bus(1, 6'h1C, 8'h20);
        bus(1, 6'h04, 8'hA0);
        repeat (3) @(negedge i_clk);
        chk(bsw, 1);
        bus(0, 6'h14, 8'h00);
        chk(q, 8'h30);
        pin <= 1'b1;
        for (n = 0; n < 600 && brun !== 1'b1; n++) @(negedge i_clk);
        chk(brun, 1);
        chk(8'(n >= 29 * MS), 1);
        bus(0, 6'h20, 8'h00);
        chk(q[7:6], 2'h3);
        chk(ibs, 0);
        ovp <= 1'b1;
        for (n = 0; n < 20 && intr !== 1'b1; n++) @(negedge i_clk);
        chk(intr, 1);
        bus(0, 6'h24, 8'h00);
        ovp <= 1'b0;
        chk(q[6], 1);
        bus(0, 6'h24, 8'h00);
        chk(q[6], 0);
        bus(1, 6'h10, 8'h02);
        repeat (3) @(negedge i_clk);
        chk(lbs, 1);
        // The fault ended the run; the exit level only matters once boost runs again.
        for (n = 0; n < 600 && brun !== 1'b1; n++) @(negedge i_clk);
        chk(brun, 1);
        @(posedge i_clk);
        bexit <= 1'b0;
        repeat (8) @(negedge i_clk);
        chk(brun, 0);
        @(posedge i_clk);
        bexit <= 1'b1;
        for (n = 0; n < 600 && brun !== 1'b1; n++) @(negedge i_clk);
        chk(brun, 1);
        @(posedge i_clk);
        bfault <= 1'b1;
        for (n = 0; n < 20 && intr !== 1'b1; n++) @(negedge i_clk);
        chk(intr, 1);
        @(posedge i_clk);
        bfault <= 1'b0;
        pin <= 1'b0;
        ovl <= 1'b1;
        repeat (8) @(posedge i_clk);
        ovl <= 1'b0;
        repeat (8) @(negedge i_clk);
        chk(bsw, 0);
        @(posedge i_clk);
        adapter <= 1'b1;
        repeat (12) @(negedge i_clk);
        chk(bsw, 1);
        chk(ibs, 1);
        chk(tload, 1);
        bus(1, 6'h1C, 8'h20);
        bdepl <= 1'b0;
        repeat (3) @(negedge i_clk);
        chk(bsw, 0);
        @(posedge i_clk);
        adapter <= 1'b0;
        repeat (8) @(negedge i_clk);
        chk(ibs, 0);
        complete_run();
    end
endmodule

//--- verilog/pwb_pkg.sv
// Constants, register map and state codes of the power path and boost control block.
// Assumes a single 250 MHz clock and a 32-bit Avalon-MM register bus with byte addresses.
// ****************************************************************************
// ****************************************************************************
package pwb_pkg;

    // Clock and time bases.
    localparam int unsigned CLK_KHZ = 250000;
    localparam int unsigned MS_CYCLES_DEF = CLK_KHZ;
    localparam int unsigned DIG_CLK_KHZ = 1500;
    localparam int unsigned DIG_DIV = CLK_KHZ / DIG_CLK_KHZ;
    localparam int unsigned BOOST_DELAY_MS = 30;
    localparam int unsigned POOR_SRC_MS = 30;
    localparam int unsigned WDT_MAX_S = 160;
    localparam int unsigned WDT_MAX_MS_DEF = WDT_MAX_S * 1000;

    // Register indices; byte address is four times the index.
    localparam int unsigned NUM_CFG = 8;
    localparam logic [3:0] IDX_CTRL = 4'h1;
    localparam logic [3:0] IDX_BAT_SEL = 4'h4;
    localparam logic [3:0] IDX_WDT = 4'h5;
    localparam logic [3:0] IDX_BOOST_CFG = 4'h6;
    localparam logic [3:0] IDX_SWITCH = 4'h7;
    localparam logic [3:0] IDX_STATUS = 4'h8;
    localparam logic [3:0] IDX_FAULT = 4'h9;

    // Field positions.
    localparam int unsigned BIT_REG_RESET = 7;
    localparam int unsigned BIT_MODE_LO = 4;
    localparam int unsigned BIT_LOWBAT_SEL = 1;
    localparam int unsigned BIT_WDT_LO = 4;
    localparam int unsigned BIT_BOOST_VOLTAGE_FIELD_LO = 4;
    localparam int unsigned BIT_HOT_LO = 2;
    localparam int unsigned BIT_SWITCH_OFF = 5;
    localparam int unsigned BIT_SRC_STAT_LO = 6;
    localparam int unsigned BIT_PWR_GOOD = 2;
    localparam int unsigned BIT_BOOST_FAULT = 6;

    // Field codes and reset values, REG07 down to REG00.
    localparam logic [1:0] MODE_BOOST = 2'h2;
    localparam logic [1:0] WDT_OFF = 2'h0;
    localparam logic [1:0] SRC_STAT_BOOST = 2'h3;
    localparam logic [1:0] SRC_STAT_NONE = 2'h0;
    localparam logic [63:0] CFG_DEFAULTS = 64'h0090300000002000;

    // Boost sequencing states.
    typedef enum logic [2:0] {
        PWB_BST_IDLE = 3'b001,
        PWB_BST_WAIT = 3'b010,
        PWB_BST_RUN = 3'b100
    } pwb_bst_state_t;

endpackage

//--- verilog/pwb_power_path_ctrl.sv
// Power path, battery switch and boost sequencing control with its register file.
// Assumes analog comparator levels arrive asynchronously and an Avalon-MM master on i_clk.
//
// Added by the designer: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps

module pwb_power_path_ctrl #(
    parameter int unsigned MS_CYCLES = pwb_pkg::MS_CYCLES_DEF,
    parameter int unsigned WDT_MAX_MS = pwb_pkg::WDT_MAX_MS_DEF
) (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_srst,
    // Avalon-MM register slave.
    input wire logic [5:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // Analog comparator levels.
    input wire logic i_vbus_uvlo_ok,
    input wire logic i_vbat_uvlo_ok,
    input wire logic i_vbat_above_depl,
    input wire logic i_vbus_above_sleep,
    input wire logic i_vbat_above_lowv,
    input wire logic i_vbat_above_boost_exit,
    input wire logic i_overload,
    input wire logic i_boost_node_ovp,
    input wire logic i_boost_fault,
    input wire logic i_vbus_src_good,
    // Device pins.
    input wire logic i_boost_request_pin,
    input wire logic i_ship_exit_pin,
    // Power stage controls.
    output logic o_battery_switch_on,
    output logic o_input_blocking_switch_on,
    output logic o_bias_regulator_en,
    output logic o_boost_run,
    output logic [3:0] o_boost_voltage_field,
    output logic [1:0] o_hot_threshold_sel,
    output logic o_low_battery_sel,
    output logic o_test_load_en,
    output logic o_dig_clk_en,
    output logic o_int
);
    import pwb_pkg::*;

    // ************************************************************************
    // Input synchronisers
    // ************************************************************************

    localparam int unsigned NSYNC = 12;

    logic [NSYNC-1:0] raw;
    logic [NSYNC-1:0] sync1_q;
    logic [NSYNC-1:0] sync2_q;
    logic ship_prev_q;

    assign raw = {i_ship_exit_pin, i_boost_request_pin, i_vbus_src_good, i_boost_fault,
                  i_boost_node_ovp, i_overload, i_vbat_above_boost_exit, i_vbat_above_lowv,
                  i_vbus_above_sleep, i_vbat_above_depl, i_vbat_uvlo_ok, i_vbus_uvlo_ok};

    // Every level from the analog side passes two flops before use.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            sync1_q <= '0;
            sync2_q <= '0;
            ship_prev_q <= 1'b0;
        end else begin
            sync1_q <= raw;
            sync2_q <= sync1_q;
            ship_prev_q <= sync2_q[11];
        end
    end

    logic vbus_ok;
    logic vbat_ok;
    logic bat_depl_ok;
    logic vbus_awake;
    logic bat_lowv_ok;
    logic bat_exit_ok;
    logic overload;
    logic node_ovp;
    logic bst_fault;
    logic src_good;
    logic boost_pin;
    logic ship_edge;

    assign vbus_ok = sync2_q[0];
    assign vbat_ok = sync2_q[1];
    assign bat_depl_ok = sync2_q[2];
    assign vbus_awake = sync2_q[3];
    assign bat_lowv_ok = sync2_q[4];
    assign bat_exit_ok = sync2_q[5];
    assign overload = sync2_q[6];
    assign node_ovp = sync2_q[7];
    assign bst_fault = sync2_q[8];
    assign src_good = sync2_q[9];
    assign boost_pin = sync2_q[10];
    // Edge taken from two consecutive synchronised samples.
    assign ship_edge = sync2_q[11] & ~ship_prev_q;

    // ************************************************************************
    // Functions
    // ************************************************************************

    // Byte at a register index of a 64-bit vector packing one byte per register.
    function automatic logic [7:0] fld8(input logic [63:0] vec, input logic [3:0] idx);
        fld8 = vec[{idx[2:0], 3'b000} +: 8];
    endfunction

    // Watchdog period in ms; each lower code halves the longest period.
    function automatic logic [31:0] wdt_limit(input logic [1:0] code);
        logic [31:0] full;
        full = WDT_MAX_MS;
        wdt_limit = full >> (2'd3 - code);
    endfunction

    // ************************************************************************
    // Millisecond tick and supply tracking
    // ************************************************************************

    logic [31:0] ms_cnt_q;
    logic ms_tick;
    logic supply_up;
    logic supply_prev_q;
    logic vbus_present;
    logic vbus_prev_q;
    logic adapter_attach;

    assign ms_tick = (ms_cnt_q == MS_CYCLES - 1);
    assign supply_up = vbus_ok | vbat_ok;
    assign vbus_present = vbus_ok & vbus_awake;
    assign adapter_attach = vbus_present & ~vbus_prev_q;

    // Free-running millisecond base shared by all slow timers.
    always_ff @(posedge i_clk) begin
        if (i_srst || ms_tick) begin
            ms_cnt_q <= '0;
        end else begin
            ms_cnt_q <= ms_cnt_q + 32'h00000001;
        end
    end

    // Previous supply levels for edge detection.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            supply_prev_q <= 1'b0;
            vbus_prev_q <= 1'b0;
        end else begin
            supply_prev_q <= supply_up;
            vbus_prev_q <= vbus_present;
        end
    end

    // ************************************************************************
    // Avalon-MM slave
    // ************************************************************************

    logic [7:0] cfg_q [0:NUM_CFG-1];
    logic [3:0] idx;
    logic mapped;
    logic req;
    logic wr_acc;
    logic rd_acc;
    logic lane0_wr;
    logic reg_reset;
    logic soft_rst;
    logic sw_off_q;
    logic fault_q;
    logic pg_q;
    logic [7:0] rd_byte;
    pwb_bst_state_t bst_q;

    assign idx = i_avs_address[5:2];
    assign mapped = (i_avs_address[1:0] == 2'b00) && (idx <= IDX_FAULT);
    assign req = i_avs_read | i_avs_write;
    assign wr_acc = i_avs_write & ~o_avs_waitrequest & mapped;
    assign rd_acc = i_avs_read & ~o_avs_waitrequest & mapped;
    assign lane0_wr = wr_acc & i_avs_byteenable[0];
    assign reg_reset = lane0_wr && (idx == IDX_CTRL) && i_avs_writedata[BIT_REG_RESET];
    // Registers sit at default while no supply is up and on each supply rise.
    assign soft_rst = ~supply_up | (supply_up & ~supply_prev_q) | reg_reset;

    // One wait cycle per access keeps read data a clean flop output.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_avs_waitrequest <= 1'b1;
        end else if (req && o_avs_waitrequest) begin
            o_avs_waitrequest <= 1'b0;
        end else begin
            o_avs_waitrequest <= 1'b1;
        end
    end

    // Read multiplexer; live state is folded into the stored bytes.
    always_comb begin
        rd_byte = 8'h00;
        if (idx < IDX_STATUS) begin
            rd_byte = cfg_q[idx[2:0]];
            if (idx == IDX_SWITCH) begin
                rd_byte[BIT_SWITCH_OFF] = sw_off_q;
            end
        end else if (idx == IDX_STATUS) begin
            rd_byte[BIT_SRC_STAT_LO +: 2] = (bst_q == PWB_BST_RUN) ? SRC_STAT_BOOST : SRC_STAT_NONE;
            rd_byte[BIT_PWR_GOOD] = pg_q;
        end else begin
            rd_byte[BIT_BOOST_FAULT] = fault_q;
        end
    end

    // Data is captured in the wait cycle so it stands when waitrequest drops.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_avs_readdata <= 32'h00000000;
        end else if (i_avs_read && o_avs_waitrequest) begin
            o_avs_readdata <= mapped ? {24'h000000, rd_byte} : 32'h00000000;
        end
    end

    // Stored configuration bytes; the reset bit never stays set.
    always_ff @(posedge i_clk) begin
        if (i_srst || soft_rst) begin
            for (int i = 0; i < NUM_CFG; i++) begin
                cfg_q[i] <= fld8(CFG_DEFAULTS, 4'(i));
            end
        end else if (lane0_wr && (idx < IDX_STATUS)) begin
            cfg_q[idx[2:0]] <= i_avs_writedata[7:0];
        end
    end

    // ************************************************************************
    // Watchdog
    // ************************************************************************

    logic [1:0] wdt_code;
    logic [31:0] wdt_ms_q;
    logic wdt_expire;

    assign wdt_code = cfg_q[IDX_WDT[2:0]][BIT_WDT_LO +: 2];
    assign wdt_expire = ms_tick && (wdt_code != WDT_OFF) && (wdt_ms_q >= wdt_limit(wdt_code) - 1);

    // Any register write kicks the watchdog; code zero stops it for shipping.
    always_ff @(posedge i_clk) begin
        if (i_srst || soft_rst || wr_acc || wdt_code == WDT_OFF || wdt_expire) begin
            wdt_ms_q <= '0;
        end else if (ms_tick) begin
            wdt_ms_q <= wdt_ms_q + 32'h00000001;
        end
    end

    // ************************************************************************
    // Battery switch
    // ************************************************************************

    logic clear_ev;
    logic ovl_q;

    assign clear_ev = adapter_attach | ship_edge | wdt_expire | reg_reset;

    // Clear events win over a host write in the same cycle.
    always_ff @(posedge i_clk) begin
        if (i_srst || soft_rst) begin
            sw_off_q <= 1'b0;
        end else if (clear_ev) begin
            sw_off_q <= 1'b0;
        end else if (lane0_wr && idx == IDX_SWITCH) begin
            sw_off_q <= i_avs_writedata[BIT_SWITCH_OFF];
        end
    end

    // Overload latch in any mode; a new attach frees it, but a live overload keeps it set.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            ovl_q <= 1'b0;
        end else if (overload) begin
            ovl_q <= 1'b1;
        end else if (adapter_attach) begin
            ovl_q <= 1'b0;
        end
    end

    // Switch closes on battery alone above depletion, or with input present.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_battery_switch_on <= 1'b0;
        end else begin
            o_battery_switch_on <= ~sw_off_q & ~ovl_q & ~overload & (vbus_present | bat_depl_ok);
        end
    end

    // ************************************************************************
    // Boost sequencing
    // ************************************************************************

    logic lowbat_sel;
    logic boost_allow;
    logic boost_exit;
    logic fault_ev;
    logic [7:0] bst_ms_q;

    assign lowbat_sel = cfg_q[IDX_BAT_SEL[2:0]][BIT_LOWBAT_SEL];
    assign boost_allow = bat_lowv_ok & ~vbus_awake & boost_pin
                       & (cfg_q[IDX_CTRL[2:0]][BIT_MODE_LO +: 2] == MODE_BOOST);
    assign boost_exit = lowbat_sel ? ~bat_exit_ok : ~bat_lowv_ok;
    assign fault_ev = (bst_q == PWB_BST_RUN) & (node_ovp | bst_fault);

    // Delay runs on the millisecond base; losing any condition restarts it.
    always_ff @(posedge i_clk) begin
        if (i_srst || soft_rst) begin
            bst_q <= PWB_BST_IDLE;
            bst_ms_q <= 8'h00;
        end else begin
            case (bst_q)
                PWB_BST_IDLE: begin
                    bst_ms_q <= 8'h00;
                    if (boost_allow) begin
                        bst_q <= PWB_BST_WAIT;
                    end
                end
                PWB_BST_WAIT: begin
                    if (!boost_allow) begin
                        bst_q <= PWB_BST_IDLE;
                    end else if (ms_tick) begin
                        bst_ms_q <= bst_ms_q + 8'h01;
                        if (bst_ms_q == 8'(BOOST_DELAY_MS - 1)) begin
                            bst_q <= PWB_BST_RUN;
                        end
                    end
                end
                PWB_BST_RUN: begin
                    if (!boost_allow || boost_exit || fault_ev) begin
                        bst_q <= PWB_BST_IDLE;
                    end
                end
                default: begin
                    bst_q <= PWB_BST_IDLE;
                end
            endcase
        end
    end

    // Sticky boost fault; a read of the fault register clears it unless a new fault lands.
    always_ff @(posedge i_clk) begin
        if (i_srst || soft_rst) begin
            fault_q <= 1'b0;
        end else if (fault_ev) begin
            fault_q <= 1'b1;
        end else if (rd_acc && idx == IDX_FAULT && o_avs_readdata[BIT_BOOST_FAULT]) begin
            // Only a fault that the host has actually seen is cleared.
            fault_q <= 1'b0;
        end
    end

    // ************************************************************************
    // Input source qualification and charge path
    // ************************************************************************

    logic [7:0] src_ms_q;
    logic pg_set;

    assign pg_set = o_test_load_en && ms_tick && (src_ms_q == 8'(POOR_SRC_MS - 1)) && src_good;

    // Test load for a fixed window after attach; source removal ends it early.
    always_ff @(posedge i_clk) begin
        if (i_srst || !vbus_present) begin
            o_test_load_en <= 1'b0;
            src_ms_q <= 8'h00;
            pg_q <= 1'b0;
        end else if (adapter_attach) begin
            o_test_load_en <= 1'b1;
            src_ms_q <= 8'h00;
        end else if (o_test_load_en && ms_tick) begin
            src_ms_q <= src_ms_q + 8'h01;
            if (src_ms_q == 8'(POOR_SRC_MS - 1)) begin
                o_test_load_en <= 1'b0;
                pg_q <= src_good;
            end
        end
    end

    // Blocking switch follows the sleep comparator; never closed while boosting.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_input_blocking_switch_on <= 1'b0;
        end else begin
            o_input_blocking_switch_on <= vbus_present & (bst_q != PWB_BST_RUN);
        end
    end

    // Bias regulator only with a real input or in boost; battery alone stays quiet.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_bias_regulator_en <= 1'b0;
            o_boost_run <= 1'b0;
        end else begin
            o_bias_regulator_en <= vbus_present | (bst_q == PWB_BST_RUN);
            o_boost_run <= (bst_q == PWB_BST_RUN);
        end
    end

    // ************************************************************************
    // Digital clock enable, field outputs and interrupt
    // ************************************************************************

    logic [7:0] dig_cnt_q;

    // Default bytes of the trim registers, used while the block is in reset.
    localparam logic [7:0] BOOST_CFG_DEF = fld8(CFG_DEFAULTS, IDX_BOOST_CFG);
    localparam logic [7:0] BAT_SEL_DEF = fld8(CFG_DEFAULTS, IDX_BAT_SEL);

    // Integer divide rounds the rate slightly high; a fractional divider was not worth it.
    always_ff @(posedge i_clk) begin
        if (i_srst || !o_bias_regulator_en) begin
            dig_cnt_q <= 8'h00;
            o_dig_clk_en <= 1'b0;
        end else if (dig_cnt_q == 8'(DIG_DIV - 1)) begin
            dig_cnt_q <= 8'h00;
            o_dig_clk_en <= 1'b1;
        end else begin
            dig_cnt_q <= dig_cnt_q + 8'h01;
            o_dig_clk_en <= 1'b0;
        end
    end

    // Analog trims copied from configuration; defaults apply during soft reset.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_boost_voltage_field <= BOOST_CFG_DEF[BIT_BOOST_VOLTAGE_FIELD_LO +: 4];
            o_hot_threshold_sel <= BOOST_CFG_DEF[BIT_HOT_LO +: 2];
            o_low_battery_sel <= BAT_SEL_DEF[BIT_LOWBAT_SEL];
        end else begin
            o_boost_voltage_field <= cfg_q[IDX_BOOST_CFG[2:0]][BIT_BOOST_VOLTAGE_FIELD_LO +: 4];
            o_hot_threshold_sel <= cfg_q[IDX_BOOST_CFG[2:0]][BIT_HOT_LO +: 2];
            o_low_battery_sel <= lowbat_sel;
        end
    end

    // Interrupt pulse on a boost fault or on a source passing qualification.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_int <= 1'b0;
        end else begin
            o_int <= fault_ev | pg_set;
        end
    end

endmodule
